// ===== rtl/lst_pkg.sv
package lst_pkg;

  // Register byte offsets
  localparam logic [7:0] LST_OFF_TX_BUF = 8'h00;
  localparam logic [7:0] LST_OFF_PIN_STAT = 8'h04;
  localparam logic [7:0] LST_OFF_HDR_CFG = 8'h08;
  localparam logic [7:0] LST_OFF_CTRL = 8'h0C;
  localparam logic [7:0] LST_OFF_FLAG = 8'h10;
  localparam logic [7:0] LST_OFF_INT_STAT = 8'h14;
  localparam logic [7:0] LST_OFF_INT_MASK = 8'h18;
  localparam logic [7:0] LST_OFF_BIT_DIV = 8'h1C;

  // Field positions
  localparam int LST_TXB_MSB = 7;
  localparam int LST_PIN_TX_BIT = 2;
  localparam int LST_PIN_RX_BIT = 1;
  localparam int LST_DEL_LSB = 8;
  localparam int LST_DEL_MSB = 9;
  localparam int LST_BRK_LSB = 0;
  localparam int LST_BRK_MSB = 2;
  localparam int LST_CTRL_LIN_BIT = 0;
  localparam int LST_CTRL_HDR_BIT = 1;
  localparam int LST_FLAG_RDY_BIT = 0;
  localparam int LST_FLAG_BUSY_BIT = 1;
  localparam int LST_INT_TX_BIT = 0;
  localparam int LST_INT_HDR_BIT = 1;
  localparam int LST_DIV_MSB = 15;

  // Reset values
  localparam logic [1:0] LST_DEL_RESET = 2'h0;
  localparam logic [2:0] LST_BRK_RESET = 3'h0;
  localparam logic [1:0] LST_INT_MASK_RESET = 2'h0;
  localparam logic [15:0] LST_BIT_DIV_RESET = 16'h00C7;

  // Line timing in bit times, and the sync byte value
  localparam logic [4:0] LST_BRK_MIN_BITS = 5'h0D;
  localparam logic [4:0] LST_ONE = 5'h01;
  localparam logic [4:0] LST_DATA_LAST = 5'h07;
  localparam logic [7:0] LST_SYNC_BYTE = 8'h55;

  typedef enum logic [2:0] {
    LST_IDLE,
    LST_BREAK,
    LST_DELIM,
    LST_START,
    LST_DATA,
    LST_STOP
  } lst_tx_e;

endpackage : lst_pkg

// ===== rtl/lst_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lst_bit_timer
  import lst_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic restart,
  input wire logic [15:0] div,
  // Bit boundary
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } lst_timer_s;

  lst_timer_s st_reg;
  lst_timer_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (restart) begin
      st_next.cnt = 16'h0000;
    end else if (st_reg.cnt >= div) begin
      // Greater-or-equal so a shrunk divisor cannot strand the count
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule : lst_bit_timer
`default_nettype wire

// ===== rtl/lst_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - buffer to shifter move sets ready flag
// R2 - enabled transmit interrupt raised on that move
// R3 - software writes short characters right aligned
// R4 - reserved bits read zero, ignore writes
// R5 - pin status bit 2 shows transmit pin
// R6 - pin status bit 1 shows receive pin
// R7 - delimiter lasts code plus one bits
// R8 - break lasts thirteen plus extension bits
// R9 - break extension resets to zero
// R10 - header drives break low, delimiter high
module lst_top
  import lst_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial line
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [7:0] buf_data;
    logic buf_full;
    logic ready_flag;
    logic lin_mode;
    logic [1:0] del_code;
    logic [2:0] brk_code;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [15:0] bit_div;
    lst_tx_e tx_state;
    logic hdr_active;
    logic [7:0] shift;
    logic [4:0] bit_cnt;
    logic tx_pin;
    logic [2:0] rx_sync;
    logic rx_level;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } lst_state_s;

  lst_state_s st_reg;
  lst_state_s st_next;
  logic tick;
  logic timer_restart;

  // Last bit index of the break for a given extension code
  function automatic logic [4:0] brk_last(input logic [2:0] code);
    brk_last = LST_BRK_MIN_BITS - LST_ONE + {2'b00, code};
  endfunction : brk_last

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  // Read value of the register at address a
  function automatic logic [31:0] reg_value(input lst_state_s s,
                                            input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (addr_is(a, LST_OFF_PIN_STAT)) begin
      v[LST_PIN_TX_BIT] = s.tx_pin; // R5
      v[LST_PIN_RX_BIT] = s.rx_level; // R6
    end else if (addr_is(a, LST_OFF_HDR_CFG)) begin
      v[LST_DEL_MSB:LST_DEL_LSB] = s.del_code; // R4
      v[LST_BRK_MSB:LST_BRK_LSB] = s.brk_code; // R4
    end else if (addr_is(a, LST_OFF_CTRL)) begin
      v[LST_CTRL_LIN_BIT] = s.lin_mode;
    end else if (addr_is(a, LST_OFF_FLAG)) begin
      v[LST_FLAG_RDY_BIT] = s.ready_flag;
      v[LST_FLAG_BUSY_BIT] = (s.tx_state != LST_IDLE);
    end else if (addr_is(a, LST_OFF_INT_STAT)) begin
      v[LST_INT_HDR_BIT:LST_INT_TX_BIT] = s.int_status;
    end else if (addr_is(a, LST_OFF_INT_MASK)) begin
      v[LST_INT_HDR_BIT:LST_INT_TX_BIT] = s.int_mask;
    end else if (addr_is(a, LST_OFF_BIT_DIV)) begin
      v[LST_DIV_MSB:0] = s.bit_div;
    end
    // Transmit buffer is write only and reads zero
    reg_value = v;
  endfunction : reg_value

  lst_bit_timer u_bit_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(timer_restart),
    .div(st_reg.bit_div),
    .tick(tick)
  );

  always_comb begin
    logic wr_dp;
    logic rd_dp;
    logic buf_wr;
    logic hdr_req;
    logic [1:0] events;
    logic [1:0] clr;
    wr_dp = 1'b0;
    rd_dp = 1'b0;
    buf_wr = 1'b0;
    hdr_req = 1'b0;
    events = 2'b00;
    clr = 2'b00;
    st_next = st_reg;

    // Receive pin: three stages, level moves when last two agree
    st_next.rx_sync = {st_reg.rx_sync[1:0], serial_in_pin};
    if (st_reg.rx_sync[2] == st_reg.rx_sync[1]) begin
      st_next.rx_level = st_reg.rx_sync[2]; // R6
    end

    // Data phase of a captured transfer
    wr_dp = st_reg.ap_valid && st_reg.ap_write;
    rd_dp = st_reg.ap_valid && !st_reg.ap_write;
    st_next.ap_valid = 1'b0;

    if (wr_dp) begin
      if (addr_is(st_reg.ap_addr, LST_OFF_TX_BUF)) begin
        // Buffer only accepts bytes in SCI-compatible mode
        if (!st_reg.lin_mode) begin
          buf_wr = 1'b1;
          st_next.buf_data = hwdata[LST_TXB_MSB:0]; // R3 R4
          st_next.buf_full = 1'b1;
          st_next.ready_flag = 1'b0;
        end
      end else if (addr_is(st_reg.ap_addr, LST_OFF_HDR_CFG)) begin
        st_next.del_code = hwdata[LST_DEL_MSB:LST_DEL_LSB]; // R4
        st_next.brk_code = hwdata[LST_BRK_MSB:LST_BRK_LSB]; // R4
      end else if (addr_is(st_reg.ap_addr, LST_OFF_CTRL)) begin
        st_next.lin_mode = hwdata[LST_CTRL_LIN_BIT];
        hdr_req = hwdata[LST_CTRL_HDR_BIT] && hwdata[LST_CTRL_LIN_BIT];
      end else if (addr_is(st_reg.ap_addr, LST_OFF_INT_MASK)) begin
        st_next.int_mask = hwdata[LST_INT_HDR_BIT:LST_INT_TX_BIT];
      end else if (addr_is(st_reg.ap_addr, LST_OFF_BIT_DIV)) begin
        st_next.bit_div = hwdata[LST_DIV_MSB:0];
      end
    end

    // Read data is registered in the single wait state
    if (rd_dp) begin
      st_next.rdata = reg_value(st_reg, st_reg.ap_addr);
      if (addr_is(st_reg.ap_addr, LST_OFF_INT_STAT)) begin
        clr = st_reg.int_status;
      end
    end

    // Address phase capture; blocked while a read stalls the bus
    if (hsel && htrans[1] && hready) begin
      st_next.ap_valid = 1'b1;
      st_next.ap_write = hwrite;
      st_next.ap_addr = haddr[7:0];
    end

    // Transmitter
    case (st_reg.tx_state)
      LST_IDLE: begin
        if (hdr_req) begin
          st_next.tx_state = LST_BREAK;
          st_next.hdr_active = 1'b1;
          st_next.bit_cnt = 5'h00;
        end else if (!st_reg.lin_mode && st_reg.buf_full && !buf_wr) begin
          // Move is held off in a buffer write cycle so a new byte is not lost
          st_next.shift = st_reg.buf_data;
          st_next.buf_full = 1'b0;
          st_next.ready_flag = 1'b1; // R1
          events[LST_INT_TX_BIT] = 1'b1; // R2
          st_next.hdr_active = 1'b0;
          st_next.tx_state = LST_START;
        end
      end
      LST_BREAK: begin
        if (tick) begin
          if (st_reg.bit_cnt == brk_last(st_reg.brk_code)) begin // R8
            st_next.tx_state = LST_DELIM;
            st_next.bit_cnt = 5'h00;
          end else begin
            st_next.bit_cnt = st_reg.bit_cnt + LST_ONE;
          end
        end
      end
      LST_DELIM: begin
        if (tick) begin
          if (st_reg.bit_cnt == {3'b000, st_reg.del_code}) begin // R7
            st_next.tx_state = LST_START;
            st_next.shift = LST_SYNC_BYTE;
            st_next.bit_cnt = 5'h00;
          end else begin
            st_next.bit_cnt = st_reg.bit_cnt + LST_ONE;
          end
        end
      end
      LST_START: begin
        if (tick) begin
          st_next.tx_state = LST_DATA;
          st_next.bit_cnt = 5'h00;
        end
      end
      LST_DATA: begin
        if (tick) begin
          st_next.shift = {1'b0, st_reg.shift[7:1]};
          if (st_reg.bit_cnt == LST_DATA_LAST) begin
            st_next.tx_state = LST_STOP;
          end else begin
            st_next.bit_cnt = st_reg.bit_cnt + LST_ONE;
          end
        end
      end
      LST_STOP: begin
        if (tick) begin
          st_next.tx_state = LST_IDLE;
          if (st_reg.hdr_active) begin
            events[LST_INT_HDR_BIT] = 1'b1;
          end
          st_next.hdr_active = 1'b0;
        end
      end
      default: begin
        st_next.tx_state = LST_IDLE;
      end
    endcase

    // Line level follows the next state so it changes with the bit edge
    case (st_next.tx_state)
      LST_BREAK: st_next.tx_pin = 1'b0; // R10
      LST_START: st_next.tx_pin = 1'b0;
      LST_DATA: st_next.tx_pin = st_next.shift[0];
      LST_DELIM: st_next.tx_pin = 1'b1; // R10
      default: st_next.tx_pin = 1'b1;
    endcase

    // Set wins over read clear
    st_next.int_status = (st_reg.int_status & ~clr) | events; // R2
  end

  assign timer_restart = (st_reg.tx_state == LST_IDLE) &&
                         (st_next.tx_state != LST_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.ready_flag <= 1'b1;
      st_reg.del_code <= LST_DEL_RESET;
      st_reg.brk_code <= LST_BRK_RESET; // R9
      st_reg.int_mask <= LST_INT_MASK_RESET;
      st_reg.bit_div <= LST_BIT_DIV_RESET;
      st_reg.tx_state <= LST_IDLE;
      st_reg.tx_pin <= 1'b1;
      st_reg.rx_sync <= 3'h7;
      st_reg.rx_level <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout = !(st_reg.ap_valid && !st_reg.ap_write);
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign serial_out_pin = st_reg.tx_pin;
  assign irq = |(st_reg.int_status & st_reg.int_mask); // R2

endmodule : lst_top
`default_nettype wire

// ===== tb/lst_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lst_top_properties
  import lst_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Line and interrupt
  input wire logic serial_out_pin,
  input wire logic irq
);
  logic rd;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite
    |=> hreadyout) else $error("write got a wait state");
  a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_pin_tx_level: assert property (
    rd && haddr[7:0] == LST_OFF_PIN_STAT
    |=> ##1 hrdata[LST_PIN_TX_BIT] == $past(serial_out_pin))
    else $error("pin status tx bit wrong");
  a_pin_resv_zero: assert property (
    rd && haddr[7:0] == LST_OFF_PIN_STAT
    |=> ##1 hrdata[31:3] == 29'h0 && !hrdata[0])
    else $error("pin status reserved bits set");
  a_cfg_resv_zero: assert property (
    rd && haddr[7:0] == LST_OFF_HDR_CFG
    |=> ##1 hrdata[31:10] == 22'h0 && hrdata[7:3] == 5'h0)
    else $error("config reserved bits set");
  a_line_idle: assert property ($rose(hresetn) |-> serial_out_pin)
    else $error("line not idle after reset");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout)
    |-> $stable(hrdata)) else $error("read data moved");
  c_read: cover property (rd ##2 hreadyout);
  c_break: cover property (!serial_out_pin [*8]);
  c_irq: cover property ($rose(irq));
endmodule : lst_top_properties
bind lst_top lst_top_properties u_lst_top_properties (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .serial_out_pin, .irq);
`default_nettype wire

// ===== tb/lst_line_peer.sv
`timescale 1ns/1ps
`default_nettype none
module lst_line_peer #(
  parameter int BITCLK = 4
) (
  // Clock, reset and line
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic serial_out_pin,
  input wire logic rx_level,
  output logic serial_in_pin,
  // Observations
  output logic [7:0] got_byte,
  output int n_frames,
  output int brk_len,
  output int del_len
);
  logic prev;
  logic after_brk;
  int run;
  int ck;
  // Receive line is a plain level from the bench, always driven
  assign serial_in_pin = rx_level;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev <= 1'b1;
      after_brk <= 1'b0;
      run <= 0;
      ck <= 0;
      n_frames <= 0;
    end else begin
      prev <= serial_out_pin;
      run <= (serial_out_pin != prev) ? 1 : run + 1;
      // Long low run only counts as a break
      if (!prev && serial_out_pin && run > 10 * BITCLK) begin
        brk_len <= run;
        after_brk <= 1'b1;
      end
      if (prev && !serial_out_pin && after_brk) begin
        del_len <= run;
        after_brk <= 1'b0;
      end
      // Frame receiver samples mid bit, LSB first
      if (ck == 0 && prev && !serial_out_pin) ck <= 1;
      else if (ck != 0) begin
        ck <= ck + 1;
        if (ck % BITCLK == BITCLK / 2 && ck > BITCLK) begin
          if (ck / BITCLK <= 8) got_byte <= {serial_out_pin, got_byte[7:1]};
          else begin
            n_frames <= n_frames + 1;
            ck <= 0;
          end
        end
      end
    end
  end
endmodule : lst_line_peer
`default_nettype wire

// ===== tb/lst_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lst_top_bench;
  import lst_pkg::*;
  logic hclk, hreadyout, hresp, serial_out_pin, serial_in_pin, irq;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rx_level = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv, d;
  logic [7:0] got_byte;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int nf, n_frames, brk_len, del_len;
  lst_top u_lst_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .serial_out_pin, .serial_in_pin, .irq);
  lst_line_peer #(.BITCLK(4)) u_lst_line_peer (.hclk, .hresetn,
    .serial_out_pin, .rx_level, .serial_in_pin, .got_byte, .n_frames,
    .brk_len, .del_len);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // Whole run needs about 1400 cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    d = $urandom(32'h14a9);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, LST_OFF_HDR_CFG, 0);
    chk("cfg", rv, 32'h0);
    xfer(0, LST_OFF_FLAG, 0);
    chk("rdy", rv & 32'h1, 32'h1);
    $display("test reset done");
    repeat (4) begin
      d = $urandom;
      xfer(1, LST_OFF_HDR_CFG, d);
      xfer(0, LST_OFF_HDR_CFG, 0);
      chk("cfg", rv, d & 32'h307);
    end
    for (int i = 0; i < 2; i++) begin
      rx_level <= i[0];
      repeat (6) @(posedge hclk);
      xfer(1, LST_OFF_PIN_STAT, 32'hFFFFFFFF);
      xfer(0, LST_OFF_PIN_STAT, 0);
      chk("pin", rv, {29'h0, 1'b1, i[0], 1'b0});
    end
    $display("test fields done");
    xfer(1, LST_OFF_BIT_DIV, 32'h3);
    for (int i = 0; i < 3; i++) begin
      xfer(1, LST_OFF_INT_MASK, {31'h0, i != 2});
      // Upper bits random: software need not clear them
      d = $urandom;
      if (i == 1) d[7:0] = 8'h01;
      nf = n_frames;
      xfer(1, LST_OFF_TX_BUF, d);
      xfer(0, LST_OFF_FLAG, 0);
      chk("rdy", rv & 32'h1, 32'h1);
      chk("irq", {31'h0, irq}, {31'h0, i != 2});
      while (n_frames == nf) @(posedge hclk);
      chk("byte", {24'h0, got_byte}, {24'h0, d[7:0]});
      xfer(0, LST_OFF_INT_STAT, 0);
      chk("ist", rv & 32'h1, 32'h1);
      @(posedge hclk);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    $display("test sci done");
    for (int i = 0; i < 8; i++) begin
      repeat (8) @(posedge hclk);
      xfer(1, LST_OFF_HDR_CFG, {22'h0, i[1:0], 5'h0, i[2:0]});
      nf = n_frames;
      xfer(1, LST_OFF_CTRL, 32'h3);
      while (n_frames < nf + 2) @(posedge hclk);
      chk("brk", (brk_len + 2) / 4, 13 + i);
      chk("del", (del_len + 2) / 4, 1 + i % 4);
      chk("sync", {24'h0, got_byte}, {24'h0, LST_SYNC_BYTE});
      // Header done flag lands at the end of the stop bit
      repeat (8) @(posedge hclk);
      xfer(0, LST_OFF_INT_STAT, 0);
      chk("hdone", rv & 32'h2, 32'h2);
    end
    $display("test header done");
    tally_and_finish();
  end
endmodule : lst_top_bench
`default_nettype wire
